// *** logic/wmt_mask_tester.sv ***
/*
 * wmt_mask_tester: mask based pass/fail checker for one displayed trace.
 * Assumes the acquisition side streams one trace per trigger, one point
 * per accepted beat, point 0 first and last flagged, and that it stops
 * acquiring while acqStop is high. Commands are one-cycle pulses.
 */
`timescale 1ns/1ps
module wmt_mask_tester (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire wmt_pkg::wmt_cfg_s cfg,
   input wire wmt_pkg::wmt_cmd_s cmd,
   input wire wmt_pkg::wmt_acq_s acq,
   output logic acqReady,
   output logic acqStop,
   output logic auxPulse,
   output logic soundReq,
   output logic testRunning,
   output logic [wmt_pkg::TRACE_PTS-1:0] failMarks,
   output wmt_pkg::wmt_res_s res
);
   import wmt_pkg::*;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   function automatic logic [TOL_W-1:0] clampTol(logic [TOL_W-1:0] t);
      if (t < TOL_MIN) begin
         return TOL_MIN;
      end
      if (t > TOL_MAX) begin
         return TOL_MAX;
      end
      return t;
   endfunction

   function automatic logic [IDX_W-1:0] winLo(logic [IDX_W-1:0] i,
                                              logic [IDX_W-1:0] h);
      return (i > h) ? i - h : '0;
   endfunction

   function automatic logic [IDX_W-1:0] winHi(logic [IDX_W-1:0] i,
                                              logic [IDX_W-1:0] h);
      logic [IDX_W:0] s;
      s = {1'b0, i} + {1'b0, h};
      return (s > {1'b0, LAST_IDX}) ? LAST_IDX : s[IDX_W-1:0];
   endfunction

   wmt_state_e state_ff;
   logic [IDX_W-1:0] ptr_ff;
   logic failAcc_ff;
   logic verdictFail_ff;
   logic [SAMP_W-1:0] trace_ff [TRACE_PTS];
   logic [SAMP_W-1:0] upper_ff [TRACE_PTS];
   logic [SAMP_W-1:0] lower_ff [TRACE_PTS];
   logic [SAMP_W-1:0] savedUp_ff [TRACE_PTS];
   logic [SAMP_W-1:0] savedLo_ff [TRACE_PTS];
   logic [TRACE_PTS-1:0] failMap_ff;
   logic [IDX_W-1:0] bi_ff;
   logic [IDX_W-1:0] bj_ff;
   logic [IDX_W-1:0] hx_ff;
   logic [SAMP_W-1:0] vy_ff;
   logic [SAMP_W-1:0] bMax_ff;
   logic [SAMP_W-1:0] bMin_ff;
   logic buildFromRun_ff;
   logic [CNT_W-1:0] failCnt_ff;
   logic [CNT_W-1:0] passCnt_ff;
   logic [CNT_W-1:0] totalCnt_ff;

   logic beat;
   logic idleCmd;
   logic [SAMP_W-1:0] srcSamp;
   logic pointOut;
   logic srcShown;
   logic [15:0] hxWide;
   logic [15:0] vyWide;
   logic [IDX_W-1:0] loI;
   logic [IDX_W-1:0] hiI;
   logic [SAMP_W-1:0] bT;
   logic [SAMP_W-1:0] curMax;
   logic [SAMP_W-1:0] curMin;
   logic [SAMP_W:0] upSum;
   logic [SAMP_W:0] loDiff;
   logic buildStep;
   logic failNow;

   // a new trace is only taken between verdicts
   assign acqReady = (state_ff == WMT_STOP) || (state_ff == WMT_RUN);
   assign beat = acq.valid && acqReady && (ptr_ff <= LAST_IDX);
   assign idleCmd = acqReady && (ptr_ff == '0);
   assign srcSamp = acq.samp[cfg.srcSel];
   assign srcShown = cfg.chanShown[cfg.srcSel];
   assign pointOut = (srcSamp > upper_ff[ptr_ff]) ||
                     (srcSamp < lower_ff[ptr_ff]);
   assign acqStop = (state_ff == WMT_HALT);
   assign testRunning = (state_ff != WMT_STOP) && !buildStep;
   assign buildStep = (state_ff == WMT_BUILD) && !buildFromRun_ff;
   assign failNow = (state_ff == WMT_EVAL) && verdictFail_ff;

   // tolerance in 0.02 div steps converted to points and codes
   assign hxWide = (16'(clampTol(cfg.tolX)) * 16'(PTS_PER_DIV)) /
                   16'(STEPS_PER_DIV);
   assign vyWide = (16'(clampTol(cfg.tolY)) * 16'(CODES_PER_DIV)) /
                   16'(STEPS_PER_DIV);

   // envelope of the trace over the horizontal window
   assign loI = winLo(bi_ff, hx_ff);
   assign hiI = winHi(bi_ff, hx_ff);
   assign bT = trace_ff[bj_ff];
   assign curMax = (bj_ff == loI || bT > bMax_ff) ? bT : bMax_ff;
   assign curMin = (bj_ff == loI || bT < bMin_ff) ? bT : bMin_ff;
   assign upSum = {1'b0, curMax} + {1'b0, vy_ff};
   assign loDiff = {1'b0, curMin} - {1'b0, vy_ff};

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_ff <= WMT_STOP;
         buildFromRun_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            WMT_STOP: begin
               if (cmd.buildMask && idleCmd) begin
                  state_ff <= WMT_BUILD;
                  buildFromRun_ff <= 1'b0;
               end else if (cmd.runStop && cfg.testEnable && idleCmd) begin
                  state_ff <= WMT_RUN;
               end
            end
            WMT_RUN: begin
               if (!cfg.testEnable || cmd.runStop) begin
                  state_ff <= WMT_STOP;
               end else if (beat && acq.last && srcShown) begin
                  state_ff <= WMT_EVAL;
               end else if (cmd.buildMask && idleCmd) begin
                  state_ff <= WMT_BUILD;
                  buildFromRun_ff <= 1'b1;
               end
            end
            WMT_EVAL: begin
               // results stay frozen while halted
               state_ff <= (verdictFail_ff && cfg.haltOnFail) ?
                           WMT_HALT : WMT_RUN;
            end
            WMT_HALT: begin
               if (cmd.runStop || !cfg.testEnable) begin
                  state_ff <= WMT_STOP;
               end
            end
            WMT_BUILD: begin
               if (bj_ff == hiI && bi_ff == LAST_IDX) begin
                  state_ff <= buildFromRun_ff ? WMT_RUN : WMT_STOP;
               end
            end
            default: state_ff <= WMT_STOP;
         endcase
      end
   end

   // capture, point-by-point compare and verdict
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ptr_ff <= '0;
         failAcc_ff <= 1'b0;
         verdictFail_ff <= 1'b0;
         failMap_ff <= '0;
      end else if (beat) begin
         trace_ff[ptr_ff] <= srcSamp;
         for (int k = 0; k < TRACE_PTS; k++) begin
            if (IDX_W'(k) == ptr_ff) begin
               failMap_ff[k] <= pointOut;
            end else if (ptr_ff == '0) begin
               failMap_ff[k] <= 1'b0;
            end
         end
         if (acq.last) begin
            ptr_ff <= '0;
            failAcc_ff <= 1'b0;
            // one point outside fails the whole trace
            verdictFail_ff <= ((ptr_ff != '0) && failAcc_ff) || pointOut;
         end else begin
            ptr_ff <= ptr_ff + 1'b1;
            failAcc_ff <= ((ptr_ff != '0) && failAcc_ff) || pointOut;
         end
      end
   end

   // mask build, one window element per cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bi_ff <= '0;
         bj_ff <= '0;
         hx_ff <= '0;
         vy_ff <= '0;
         bMax_ff <= SAMP_MIN;
         bMin_ff <= SAMP_MAX;
      end else if (state_ff != WMT_BUILD) begin
         // tolerances are latched so a knob turn mid-build has no effect
         bi_ff <= '0;
         bj_ff <= '0;
         hx_ff <= hxWide[IDX_W-1:0];
         vy_ff <= vyWide[SAMP_W-1:0];
      end else begin
         bMax_ff <= curMax;
         bMin_ff <= curMin;
         if (bj_ff == hiI) begin
            bi_ff <= bi_ff + 1'b1;
            bj_ff <= winLo(bi_ff + 1'b1, hx_ff);
         end else begin
            bj_ff <= bj_ff + 1'b1;
         end
      end
   end

   // live mask: reset value accepts any trace
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int k = 0; k < TRACE_PTS; k++) begin
            upper_ff[k] <= SAMP_MAX;
            lower_ff[k] <= SAMP_MIN;
         end
      end else if (state_ff == WMT_BUILD && bj_ff == hiI) begin
         upper_ff[bi_ff] <= upSum[SAMP_W] ? SAMP_MAX : upSum[SAMP_W-1:0];
         lower_ff[bi_ff] <= loDiff[SAMP_W] ? SAMP_MIN : loDiff[SAMP_W-1:0];
      end else if (cmd.loadMask && idleCmd && !cmd.buildMask) begin
         for (int k = 0; k < TRACE_PTS; k++) begin
            upper_ff[k] <= savedUp_ff[k];
            lower_ff[k] <= savedLo_ff[k];
         end
      end
   end

   // single internal mask slot
   genvar g;
   generate
      for (g = 0; g < TRACE_PTS; g++) begin : gSave
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               savedUp_ff[g] <= SAMP_MAX;
               savedLo_ff[g] <= SAMP_MIN;
            end else if (cmd.saveMask && idleCmd) begin
               savedUp_ff[g] <= upper_ff[g];
               savedLo_ff[g] <= lower_ff[g];
            end
         end
      end
   endgenerate

   // counters: cleared on start, stepped once per verdict
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         failCnt_ff <= '0;
         passCnt_ff <= '0;
         totalCnt_ff <= '0;
      end else if (state_ff == WMT_STOP && cmd.runStop && cfg.testEnable &&
                   idleCmd && !cmd.buildMask) begin
         failCnt_ff <= '0;
         passCnt_ff <= '0;
         totalCnt_ff <= '0;
      end else if (state_ff == WMT_EVAL) begin
         totalCnt_ff <= totalCnt_ff + 1'b1;
         if (verdictFail_ff) begin
            failCnt_ff <= failCnt_ff + 1'b1;
         end else begin
            passCnt_ff <= passCnt_ff + 1'b1;
         end
      end
   end

   // event outputs and display
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         auxPulse <= 1'b0;
         soundReq <= 1'b0;
         failMarks <= '0;
         res <= '0;
      end else begin
         auxPulse <= failNow && (cfg.auxSel == AUX_PASSFAIL);
         soundReq <= failNow && cfg.soundEnable;
         if (failNow && cfg.haltOnFail) begin
            failMarks <= failMap_ff;
         end else if (state_ff != WMT_HALT) begin
            failMarks <= '0;
         end
         res.show <= cfg.msgEnable;
         res.failCnt <= cfg.msgEnable ? failCnt_ff : '0;
         res.passCnt <= cfg.msgEnable ? passCnt_ff : '0;
         res.totalCnt <= cfg.msgEnable ? totalCnt_ff : '0;
      end
   end

   AST_TOTAL_SUM: assert property (
      totalCnt_ff == failCnt_ff + passCnt_ff)
      else $error("total differs from pass plus fail");

   AST_FAIL_STEP: assert property (
      failNow |=> failCnt_ff == $past(failCnt_ff) + 1'b1 &&
                  passCnt_ff == $past(passCnt_ff))
      else $error("fail counter did not step once");

   AST_PASS_STEP: assert property (
      (state_ff == WMT_EVAL && !verdictFail_ff) |=>
         passCnt_ff == $past(passCnt_ff) + 1'b1 &&
         failCnt_ff == $past(failCnt_ff))
      else $error("pass counter did not step once");

   AST_HALT_ENTRY: assert property (
      (failNow && cfg.haltOnFail) |=> acqStop ##1 (acqStop || !cfg.testEnable
                                                   || $past(cmd.runStop)))
      else $error("failure did not halt acquisition");

   AST_ONE_PULSE: assert property (
      (state_ff == WMT_HALT && $past(state_ff) == WMT_HALT) |-> !auxPulse)
      else $error("extra pulse while halted");

   AST_AUX_GATE: assert property (
      auxPulse |-> $past(cfg.auxSel) == AUX_PASSFAIL && $past(failNow))
      else $error("pulse without pass/fail aux or failure");

   AST_SOUND_GATE: assert property (
      soundReq |-> $past(cfg.soundEnable) && $past(failNow))
      else $error("sound request without enable");

   AST_START_CLEAR: assert property (
      (state_ff == WMT_RUN && $past(state_ff) == WMT_STOP) |->
         totalCnt_ff == '0 && failCnt_ff == '0 && passCnt_ff == '0)
      else $error("counters not cleared at start");

   AST_NO_OVERLAP: assert property (
      (state_ff == WMT_EVAL) |-> !acqReady ##1 $stable(ptr_ff))
      else $error("acquisition taken during verdict");

   AST_ENABLE_OFF: assert property (
      (state_ff == WMT_RUN && !cfg.testEnable) |=> state_ff == WMT_STOP)
      else $error("test kept running while disabled");
endmodule

// *** logic/wmt_pkg.sv ***
/*
 * wmt_pkg: constants and carrier types for the waveform mask tester.
 * Assumes one display trace of TRACE_PTS points per acquisition, 8-bit
 * vertical codes and tolerances given in steps of 0.02 div.
 */
package wmt_pkg;
   localparam int NUM_CH = 4;
   localparam int SAMP_W = 8;
   localparam int TRACE_PTS = 40;
   localparam int IDX_W = 6;
   localparam int CNT_W = 32;
   localparam int TOL_W = 8;
   // horizontal: 10 div across the screen, 4 points per div
   localparam int PTS_PER_DIV = 4;
   // vertical: 25 codes per div
   localparam int CODES_PER_DIV = 25;
   // tolerance code counts 0.02 div steps, so 50 steps make one div
   localparam int STEPS_PER_DIV = 50;
   localparam logic [TOL_W-1:0] TOL_MIN = 8'h01; // 0.02 div
   localparam logic [TOL_W-1:0] TOL_MAX = 8'hc8; // 4 div
   localparam logic [SAMP_W-1:0] SAMP_MAX = 8'hff;
   localparam logic [SAMP_W-1:0] SAMP_MIN = 8'h00;
   localparam logic [IDX_W-1:0] LAST_IDX = 6'h27;
   localparam logic [1:0] AUX_TRIG = 2'h0;
   localparam logic [1:0] AUX_PASSFAIL = 2'h1;

   typedef enum logic [2:0] {
      WMT_STOP = 3'b000,
      WMT_RUN = 3'b001,
      WMT_EVAL = 3'b011,
      WMT_HALT = 3'b010,
      WMT_BUILD = 3'b110
   } wmt_state_e;

   typedef struct packed {
      logic testEnable;
      logic haltOnFail;
      logic soundEnable;
      logic msgEnable;
      logic [1:0] auxSel;
      logic [1:0] srcSel;
      logic [NUM_CH-1:0] chanShown;
      logic [TOL_W-1:0] tolX;
      logic [TOL_W-1:0] tolY;
   } wmt_cfg_s;

   typedef struct packed {
      logic runStop;
      logic buildMask;
      logic saveMask;
      logic loadMask;
   } wmt_cmd_s;

   typedef struct packed {
      logic valid;
      logic last;
      logic [NUM_CH-1:0][SAMP_W-1:0] samp;
   } wmt_acq_s;

   typedef struct packed {
      logic show;
      logic [CNT_W-1:0] failCnt;
      logic [CNT_W-1:0] passCnt;
      logic [CNT_W-1:0] totalCnt;
   } wmt_res_s;
endpackage

// *** tb/tb_top.sv ***
/*
 * tb_top: self-checking bench for the waveform mask tester.
 * Assumes wmt_acq_model as the acquisition side and a 250 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
   import wmt_pkg::*;
   localparam wmt_cmd_s C_RUN = 4'h8;
   localparam wmt_cmd_s C_BLD = 4'h4;
   localparam wmt_cmd_s C_SAV = 4'h2;
   localparam wmt_cmd_s C_LD = 4'h1;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   wmt_cfg_s cfg;
   wmt_cmd_s cmd = '0;
   wmt_acq_s acq;
   logic acqReady, acqStop, auxPulse, soundReq, testRunning;
   logic [TRACE_PTS-1:0] failMarks;
   wmt_res_s res;
   logic go = 1'b0;
   logic [7:0] level = 8'h80;
   logic [7:0] badPt = 8'hff;
   logic [7:0] trDone;
   int errCount = 0;
   int cmpCount = 0;
   int auxN = 0;
   int sndN = 0;
   int passE = 0;
   int failE = 0;

   always #2 clk_sys = ~clk_sys;

   wmt_mask_tester i_wmt_mask_tester (.clk_sys(clk_sys), .resetn(resetn),
      .cfg(cfg), .cmd(cmd), .acq(acq), .acqReady(acqReady),
      .acqStop(acqStop), .auxPulse(auxPulse), .soundReq(soundReq),
      .testRunning(testRunning), .failMarks(failMarks), .res(res));
   wmt_acq_model i_wmt_acq_model (.clk_sys(clk_sys), .resetn(resetn),
      .go(go), .level(level), .badPt(badPt), .acqReady(acqReady),
      .acqStop(acqStop), .acq(acq), .trDone(trDone));

   always @(posedge clk_sys) begin
      if (auxPulse === 1'b1) auxN++;
      if (soundReq === 1'b1) sndN++;
   end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input string nm, input logic [63:0] seen,
         input logic [63:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errCount++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic chkRes;
      chk("pass", res.passCnt, passE);
      chk("fail", res.failCnt, failE);
      chk("total", res.totalCnt, passE + failE);
   endtask

   // a halted tester never takes the trace, so the wait is bounded
   task automatic send(input int n, input logic [7:0] bp);
      logic [7:0] t;
      int k;
      t = trDone + 8'(n);
      badPt = bp;
      go = 1'b1;
      k = 0;
      while (trDone !== t && k < 400) begin
         tick();
         k++;
      end
      go = 1'b0;
      tick(4);
   endtask

   task automatic cmd1(input wmt_cmd_s c);
      int k;
      cmd = c;
      tick();
      cmd = '0;
      k = 0;
      do begin
         tick();
         k++;
      end while (acqReady !== 1'b1 && k < 2000);
   endtask

   task automatic endOfTest;
      if (errCount == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      tick(20000);
      errCount++;
      endOfTest();
   end

   initial begin
      cfg = '{testEnable: 1'b1, haltOnFail: 1'b0, soundEnable: 1'b1,
         msgEnable: 1'b1, auxSel: AUX_PASSFAIL, srcSel: 2'h0,
         chanShown: 4'hf, tolX: 8'h0c, tolY: 8'h0a};
      tick(12);
      resetn = 1'b1;
      chk("running", testRunning, 0);
      chk("stop", acqStop, 0);
      send(1, 8'hff);
      cmd1(C_BLD);
      cmd1(C_RUN);
      chk("running", testRunning, 1);
      tick();
      chkRes();
      send(2, 8'hff);
      passE = 2;
      chkRes();
      send(1, 8'h27);
      failE = 1;
      chkRes();
      chk("aux", auxN, 1);
      chk("snd", sndN, 1);
      cfg.soundEnable = 1'b0;
      cfg.auxSel = AUX_TRIG;
      send(1, 8'h00);
      failE = 2;
      chkRes();
      chk("aux", auxN, 1);
      chk("snd", sndN, 1);
      cfg.chanShown = 4'he;
      send(1, 8'h00);
      chkRes();
      cfg.chanShown = 4'hf;
      cfg.srcSel = 2'h1;
      send(1, 8'h00);
      passE = 3;
      chkRes();
      cfg.srcSel = 2'h0;
      cfg.msgEnable = 1'b0;
      tick(2);
      chk("show", res.show, 0);
      chk("pass", res.passCnt, 0);
      cfg.msgEnable = 1'b1;
      cfg.soundEnable = 1'b1;
      cfg.auxSel = AUX_PASSFAIL;
      cfg.haltOnFail = 1'b1;
      send(1, 8'h05);
      failE = 3;
      chk("halt", acqStop, 1);
      chk("marks", failMarks, 40'h1 << 5);
      chk("ready", acqReady, 0);
      send(1, 8'hff);
      chkRes();
      chk("show", res.show, 1);
      chk("aux", auxN, 2);
      chk("snd", sndN, 2);
      cmd1(C_RUN);
      tick(2);
      chk("running", testRunning, 0);
      chk("stop", acqStop, 0);
      chk("marks", failMarks, 0);
      cfg.haltOnFail = 1'b0;
      level = 8'h40;
      send(1, 8'hff);
      cfg.tolY = TOL_MAX;
      cmd1(C_BLD);
      cmd1(C_SAV);
      level = 8'h80;
      cfg.tolY = TOL_MIN;
      send(1, 8'hff);
      cmd1(C_BLD);
      cmd1(C_SAV);
      level = 8'h40;
      cfg.tolY = TOL_MAX;
      send(1, 8'hff);
      cmd1(C_BLD);
      cmd1(C_RUN);
      passE = 0;
      failE = 0;
      tick();
      chkRes();
      level = 8'h20;
      send(1, 8'hff);
      passE = 1;
      chkRes();
      cmd1(C_LD);
      send(1, 8'hff);
      failE = 1;
      chkRes();
      chk("aux", auxN, 3);
      // one point of horizontal tolerance lets the spike move by one point
      level = 8'h80;
      cfg.tolX = 8'h0d;
      cfg.tolY = TOL_MIN;
      cmd1(C_RUN);
      send(1, 8'h0a);
      cmd1(C_BLD);
      cmd1(C_RUN);
      send(1, 8'h0b);
      passE = 1;
      failE = 0;
      chkRes();
      cfg.testEnable = 1'b0;
      tick(2);
      chk("running", testRunning, 0);
      endOfTest();
   end
endmodule

// *** tb/wmt_acq_model.sv ***
/*
 * wmt_acq_model: acquisition side model, streams flat 40-point traces.
 * Assumes the tester takes a beat on valid && acqReady and halts us
 * through acqStop.
 */
`timescale 1ns/1ps
module wmt_acq_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic go,
   input wire logic [7:0] level,
   input wire logic [7:0] badPt,
   input wire logic acqReady,
   input wire logic acqStop,
   output wmt_pkg::wmt_acq_s acq,
   output logic [7:0] trDone
);
   import wmt_pkg::*;
   logic busy_ff;
   logic [IDX_W-1:0] idx_ff;
   logic [7:0] noise_ff;
   logic [SAMP_W-1:0] smp;

   // no new trace may start while the tester holds acquisition stopped
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy_ff <= 1'b0;
         idx_ff <= '0;
         trDone <= 8'h00;
         noise_ff <= 8'h00;
      end else begin
         noise_ff <= noise_ff + 8'h35;
         if (!busy_ff) begin
            busy_ff <= go && !acqStop;
            idx_ff <= '0;
         end else if (acqReady) begin
            idx_ff <= idx_ff + 6'h01;
            if (idx_ff == LAST_IDX) begin
               busy_ff <= 1'b0;
               trDone <= trDone + 8'h01;
            end
         end
      end
   end

   assign smp = ({2'b00, idx_ff} == badPt) ? (level ^ 8'h40) : level;

   // fault sits on channel 0 only; idle lines churn so stale data is seen
   always_comb begin
      acq.valid = busy_ff;
      acq.last = busy_ff && (idx_ff == LAST_IDX);
      for (int c = 0; c < NUM_CH; c++) begin
         acq.samp[c] = !busy_ff ? (noise_ff ^ 8'(c)) :
                       ((c == 0) ? smp : level);
      end
   end
endmodule
